//--- hdl/tas_consts.vh
// constants for the trigger acquisition sequencer
`ifndef TAS_CONSTS_VH
`define TAS_CONSTS_VH
// register byte offsets
`define TAS_CTRL_OFF 8'h00
`define TAS_CMD_OFF 8'h04
`define TAS_STAT_OFF 8'h08
`define TAS_MAINLVL_OFF 8'h0C
`define TAS_DLYLVL_OFF 8'h10
`define TAS_PRECNT_OFF 8'h14
`define TAS_POSTCNT_OFF 8'h18
`define TAS_PEAK_OFF 8'h1C
// control field positions
`define TAS_CTRL_RUN 0
`define TAS_CTRL_SINGLE 1
`define TAS_CTRL_DELAY 2
`define TAS_CTRL_TYPE_LO 3
`define TAS_CTRL_TYPE_HI 4
`define TAS_CTRL_RUNT 5
`define TAS_CTRL_SRC_LO 6
`define TAS_CTRL_SRC_HI 7
// command bits (write one to act)
`define TAS_CMD_FORCE 0
`define TAS_CMD_MID 1
`define TAS_CMD_RUNSTOP 2
`define TAS_CMD_STOPRUNONLY 3
// trigger type codes
`define TAS_TYPE_EDGE 2'h0
`define TAS_TYPE_LOGIC 2'h1
`define TAS_TYPE_PULSE 2'h2
// reset values
`define TAS_CTRL_RST 8'h00
`define TAS_LVL_RST 16'h0000
`define TAS_PRE_RST 16'h0010
`define TAS_POST_RST 16'h0010
// bus answers
`define TAS_RESP_OKAY 2'h0
`define TAS_RESP_SLVERR 2'h2
`endif

//--- hdl/tas_trigger_sequencer.v
// trigger acquisition sequencer with axi4-lite register slave
// How it works
// - armed light only while filling pretrigger
// - ready light only while awaiting trigger
// - triggered light while filling posttrigger
// - triggered plus ready while awaiting delayed trigger
// - delayed posttrigger fill starts on delayed trigger
// - force starts acquisition as if triggered
// - force during pretrigger latched, not dropped
// - force ignored while halted
// - single mode halts after one record
// - stop-on-run/halt-only setting clears single mode
// - midpoint request sets main level halfway
// - midpoint honoured for edge, pulse, not runt
// - main and delayed levels are separate
// - three trigger types: edge, logic, pulse
// - source unchanged when channel display off
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`include "tas_consts.vh"
module tas_trigger_sequencer (
  input wire sys_clk,
  input wire reset_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire mainTrigIn,
  input wire delayTrigIn,
  input wire forceButton,
  input wire midpoint_level_button,
  input wire runStopButton,
  input wire [15:0] peakPos,
  input wire [15:0] peakNeg,
  input wire sampleStrobe,
  output wire armedLight,
  output wire readyLight,
  output wire trigdLight,
  output wire acqRun,
  output wire [15:0] mainLevel,
  output wire [15:0] delayLevel,
  output wire [1:0] trigSource
);
  // one-hot sequencer states
  localparam [5:0] ST_HALT = 6'b000001;
  localparam [5:0] ST_PRE = 6'b000010;
  localparam [5:0] ST_WAIT = 6'b000100;
  localparam [5:0] ST_WAITDLY = 6'b001000;
  localparam [5:0] ST_POST = 6'b010000;
  localparam [5:0] ST_DONE = 6'b100000;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg forcePend_reg;
  reg [7:0] ctrl_reg;
  reg [15:0] mainLvl_reg;
  reg [15:0] dlyLvl_reg;
  reg [15:0] preCnt_reg;
  reg [15:0] postCnt_reg;
  reg armed_reg;
  reg ready_reg;
  reg trigd_reg;
  reg acq_reg;
  reg awready_reg;
  reg wready_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [7:0] awAddr_reg;
  reg awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHave_reg;
  reg cmdPulse_reg;
  reg [3:0] cmdBits_reg;

  // two-flop synchronisers for the pin inputs
  reg [4:0] pinMeta_reg;
  reg [4:0] pinSync_reg;
  reg [4:0] pinLast_reg;
  wire [4:0] pinRise;
  wire [4:0] pinRaw;
  assign pinRaw = {sampleStrobe, runStopButton, midpoint_level_button,
                   forceButton, mainTrigIn};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          pinMeta_reg[gi] <= 1'b0;
          pinSync_reg[gi] <= 1'b0;
          pinLast_reg[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_reg[gi] <= pinRaw[gi];
          pinSync_reg[gi] <= pinMeta_reg[gi];
          pinLast_reg[gi] <= pinSync_reg[gi];
        end
      end
      assign pinRise[gi] = pinSync_reg[gi] & ~pinLast_reg[gi];
    end
  endgenerate

  // delayed trigger gets its own synchroniser
  reg dlyMeta_reg;
  reg dlySync_reg;
  reg dlyLast_reg;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dlyMeta_reg <= 1'b0;
      dlySync_reg <= 1'b0;
      dlyLast_reg <= 1'b0;
    end
    else
    begin
      dlyMeta_reg <= delayTrigIn;
      dlySync_reg <= dlyMeta_reg;
      dlyLast_reg <= dlySync_reg;
    end
  end

  // merged events from pins and command register
  wire trigEv = pinRise[0];
  wire dlyEv = dlySync_reg & ~dlyLast_reg;
  wire sampEv = pinRise[4];
  wire forceEv = pinRise[1] | (cmdPulse_reg & cmdBits_reg[`TAS_CMD_FORCE]);
  wire midEv = pinRise[2] | (cmdPulse_reg & cmdBits_reg[`TAS_CMD_MID]);
  wire runStopEv = pinRise[3] |
                   (cmdPulse_reg & cmdBits_reg[`TAS_CMD_RUNSTOP]);
  wire stopRunOnly = cmdPulse_reg & cmdBits_reg[`TAS_CMD_STOPRUNONLY];
  wire halted = state_reg[0] | state_reg[5];
  wire [1:0] trigType = ctrl_reg[`TAS_CTRL_TYPE_HI:`TAS_CTRL_TYPE_LO];
  // midpoint allowed for edge, pulse unless runt
  wire midOk = (trigType == `TAS_TYPE_EDGE) |
               ((trigType == `TAS_TYPE_PULSE) & ~ctrl_reg[`TAS_CTRL_RUNT]);
  wire [16:0] peakSum = {peakPos[15], peakPos} + {peakNeg[15], peakNeg};

  // sequencer next state
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_HALT, ST_DONE:
      begin
        if (runStopEv)
        begin
          state_next = ST_PRE;
          cnt_next = 16'h0000;
        end
      end
      ST_PRE:
      begin
        if (forcePend_reg | forceEv)
        begin
          state_next = ST_POST;
          cnt_next = 16'h0000;
        end
        else if (sampEv)
        begin
          if (cnt_reg + 16'h0001 >= preCnt_reg)
          begin
            state_next = ST_WAIT;
            cnt_next = 16'h0000;
          end
          else
          begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      end
      ST_WAIT:
      begin
        if (forceEv)
          state_next = ST_POST;
        else if (trigEv)
          state_next = ctrl_reg[`TAS_CTRL_DELAY] ? ST_WAITDLY : ST_POST;
        cnt_next = 16'h0000;
      end
      ST_WAITDLY:
      begin
        // posttrigger fill held until delayed event or force
        if (dlyEv | forceEv)
          state_next = ST_POST;
        cnt_next = 16'h0000;
      end
      ST_POST:
      begin
        if (sampEv)
        begin
          if (cnt_reg + 16'h0001 >= postCnt_reg)
          begin
            state_next = ctrl_reg[`TAS_CTRL_SINGLE] ? ST_DONE : ST_PRE;
            cnt_next = 16'h0000;
          end
          else
          begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      end
      default:
      begin
        state_next = ST_HALT;
        cnt_next = 16'h0000;
      end
    endcase
    if (runStopEv & ~halted)
    begin
      state_next = ST_HALT;
      cnt_next = 16'h0000;
    end
  end

  // sequencer registers and indicator lights
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_HALT;
      cnt_reg <= 16'h0000;
      forcePend_reg <= 1'b0;
      armed_reg <= 1'b0;
      ready_reg <= 1'b0;
      trigd_reg <= 1'b0;
      acq_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // force latched only while filling pretrigger, dropped when halted
      if (halted | state_next[0])
        forcePend_reg <= 1'b0;
      else if (forceEv & state_reg[1])
        forcePend_reg <= 1'b1;
      else if (state_next[4])
        forcePend_reg <= 1'b0;
      armed_reg <= state_next[1];
      ready_reg <= state_next[2] | state_next[3];
      trigd_reg <= state_next[4] | state_next[3];
      acq_reg <= ~(state_next[0] | state_next[5]);
    end
  end

  // settings: control, levels and counts
  wire wrFire = awHave_reg & wHave_reg & ~bvalid_reg;
  wire [31:0] wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                       {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  wire [31:0] wBits = wData_reg & wMask;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= `TAS_CTRL_RST;
      mainLvl_reg <= `TAS_LVL_RST;
      dlyLvl_reg <= `TAS_LVL_RST;
      preCnt_reg <= `TAS_PRE_RST;
      postCnt_reg <= `TAS_POST_RST;
      cmdPulse_reg <= 1'b0;
      cmdBits_reg <= 4'h0;
    end
    else
    begin
      cmdPulse_reg <= 1'b0;
      if (wrFire)
      begin
        case (awAddr_reg)
          // source field kept apart from display state
          `TAS_CTRL_OFF: if (wStrb_reg[0]) ctrl_reg <= wData_reg[7:0];
          `TAS_CMD_OFF:
          begin
            cmdPulse_reg <= 1'b1;
            cmdBits_reg <= wBits[3:0];
          end
          `TAS_MAINLVL_OFF: mainLvl_reg <= wBits[15:0] |
                                           (mainLvl_reg & ~wMask[15:0]);
          `TAS_DLYLVL_OFF: dlyLvl_reg <= wBits[15:0] |
                                         (dlyLvl_reg & ~wMask[15:0]);
          `TAS_PRECNT_OFF: preCnt_reg <= wBits[15:0] |
                                         (preCnt_reg & ~wMask[15:0]);
          `TAS_POSTCNT_OFF: postCnt_reg <= wBits[15:0] |
                                           (postCnt_reg & ~wMask[15:0]);
          default: ;
        endcase
      end
      // midpoint updates the main level only
      if (midEv & midOk)
        mainLvl_reg <= peakSum[16:1];
      // type code 3 is not a valid type, fold to edge
      if (ctrl_reg[`TAS_CTRL_TYPE_HI:`TAS_CTRL_TYPE_LO] == 2'h3)
        ctrl_reg[`TAS_CTRL_TYPE_HI:`TAS_CTRL_TYPE_LO] <= `TAS_TYPE_EDGE;
      if (stopRunOnly)
        ctrl_reg[`TAS_CTRL_SINGLE] <= 1'b0;
    end
  end

  // axi write channel: address and data in either order
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TAS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & awready_reg)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr[7:0];
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid & wready_reg)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wrFire)
      begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awAddr_reg > `TAS_PEAK_OFF || awAddr_reg[1:0] != 2'h0
                      || awAddr_reg == `TAS_STAT_OFF ||
                      awAddr_reg == `TAS_PEAK_OFF) ?
                     `TAS_RESP_SLVERR : `TAS_RESP_OKAY;
      end
      if (bvalid_reg & s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // axi read channel: one read at a time
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `TAS_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_arvalid & arready_reg)
      begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= `TAS_RESP_OKAY;
        case (s_axi_araddr[7:0])
          `TAS_CTRL_OFF: rdata_reg <= {24'h00_0000, ctrl_reg};
          `TAS_CMD_OFF: rdata_reg <= 32'h0000_0000;
          `TAS_STAT_OFF: rdata_reg <= {21'h00_0000, forcePend_reg, acq_reg,
                                       state_reg, trigd_reg, ready_reg,
                                       armed_reg};
          `TAS_MAINLVL_OFF: rdata_reg <= {16'h0000, mainLvl_reg};
          `TAS_DLYLVL_OFF: rdata_reg <= {16'h0000, dlyLvl_reg};
          `TAS_PRECNT_OFF: rdata_reg <= {16'h0000, preCnt_reg};
          `TAS_POSTCNT_OFF: rdata_reg <= {16'h0000, postCnt_reg};
          `TAS_PEAK_OFF: rdata_reg <= {peakPos, peakNeg};
          default:
          begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TAS_RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_reg & s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign armedLight = armed_reg;
  assign readyLight = ready_reg;
  assign trigdLight = trigd_reg;
  assign acqRun = acq_reg;
  assign mainLevel = mainLvl_reg;
  assign delayLevel = dlyLvl_reg;
  assign trigSource = ctrl_reg[`TAS_CTRL_SRC_HI:`TAS_CTRL_SRC_LO];
endmodule // tas_trigger_sequencer

//--- dv/tas_seq_assertions.sv
// property checker for the trigger acquisition sequencer
module tas_seq_assertions (
  input wire sys_clk,
  input wire reset_n,
  input wire mainTrigIn,
  input wire delayTrigIn,
  input wire forceButton,
  input wire runStopButton,
  input wire armedLight,
  input wire readyLight,
  input wire trigdLight,
  input wire acqRun
);
  logic [3:0] age [3];
  logic [2:0] ev;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // causes: main or force, delayed or force, run/halt
  assign ev = {runStopButton, delayTrigIn | forceButton,
    mainTrigIn | forceButton};
  // cycles since each cause was last high, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
    for (int i = 0; i < 3; i++)
      if (!reset_n)
        age[i] <= 4'hf;
      else if (ev[i])
        age[i] <= 4'h0;
      else if (age[i] != 4'hf)
        age[i] <= age[i] + 4'h1;
  property p_armed_only;
    armedLight |-> !readyLight && !trigdLight;
  endproperty
  a_armed_only: assert property (p_armed_only)
    else $error("armed with another light");
  property p_ready_after_pre;
    $rose(readyLight) && !trigdLight |-> $past(armedLight);
  endproperty
  a_ready_after_pre: assert property (p_ready_after_pre)
    else $error("ready without pretrigger fill");
  property p_trig_cause;
    $rose(trigdLight) |-> age[0] < 8;
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("triggered without event");
  property p_dly_wait;
    readyLight && trigdLight |=> !armedLight;
  endproperty
  a_dly_wait: assert property (p_dly_wait)
    else $error("rearmed from delayed wait");
  property p_dly_cause;
    $past(trigdLight) && trigdLight && $fell(readyLight) |-> age[1] < 8;
  endproperty
  a_dly_cause: assert property (p_dly_cause)
    else $error("delayed fill without event");
  property p_halt_dark;
    !acqRun && !$past(acqRun) |-> !(armedLight || readyLight || trigdLight);
  endproperty
  a_halt_dark: assert property (p_halt_dark)
    else $error("light on while halted");
  property p_start_cause;
    $rose(acqRun) |-> age[2] < 8;
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("run started without run/halt");
  property p_stop_cause;
    $fell(acqRun) |-> age[2] < 8 || $past(trigdLight) ||
      $past(trigdLight, 2);
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("stopped without record or run/halt");
endmodule // tas_seq_assertions
bind tas_trigger_sequencer tas_seq_assertions chk_u (.*);

//--- dv/tas_front_panel.sv
// front panel and trigger comparator model
module tas_front_panel (
  input wire logic sys_clk,
  output logic mainTrigIn,
  output logic delayTrigIn,
  output logic forceButton,
  output logic midpoint_level_button,
  output logic runStopButton,
  output logic sampleStrobe,
  output logic [15:0] peakPos,
  output logic [15:0] peakNeg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pins = 5'h0;
  logic [1:0] sampleDiv = 2'h0;
  // pin order: main, delayed, force, midpoint, run/halt
  assign {runStopButton, midpoint_level_button, forceButton,
    delayTrigIn, mainTrigIn} = pins;
  // converter sample clock runs free, one rise every 4 cycles
  always @(posedge sys_clk)
    sampleDiv <= sampleDiv + 2'h1;
  assign sampleStrobe = sampleDiv[1];
  // one press or comparator event, long enough for the synchroniser
  task automatic press(input int k);
    @(posedge sys_clk);
    pins[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pins[k] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // peak detector outputs
  task automatic setPeaks(input logic [15:0] p, input logic [15:0] n);
    @(posedge sys_clk);
    peakPos <= p;
    peakNeg <= n;
  endtask
endmodule // tas_front_panel

//--- dv/tas_trigger_sequencer_tb.sv
// self-checking bench for the trigger acquisition sequencer
`include "tas_consts.vh"
module tas_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] okResp = `TAS_RESP_OKAY;
  localparam logic [1:0] errResp = `TAS_RESP_SLVERR;
  logic sys_clk, reset_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, sampleStrobe;
  logic mainTrigIn, delayTrigIn, forceButton, midpoint_level_button;
  logic runStopButton, armedLight, readyLight, trigdLight, acqRun;
  logic [15:0] peakPos, peakNeg, mainLevel, delayLevel;
  logic [1:0] trigSource;
  logic [2:0] lights;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] ctrlVal [4] = '{8'hc0, 8'hc8, 8'hd0, 8'hf0};
  logic [15:0] midExp [4] = '{16'h28, 16'h0, 16'h28, 16'h0};
  assign lights = {trigdLight, readyLight, armedLight};
  tas_trigger_sequencer dut_u (.*);
  tas_front_panel fp_u (.*);
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end
  // bus write: sample at falling edge, act after rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r, input logic [3:0] st = 4'hf);
    logic aw, w, bv;
    logic [1:0] rsp;
    @(posedge sys_clk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bv = 1'b0;
    while (!bv)
    begin
      @(negedge sys_clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      bv = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bresp", 32'(rsp), 32'(r));
  endtask
  // bus read with expected data and answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r, input string what);
    logic ar, rv;
    logic [31:0] dat;
    logic [1:0] rsp;
    @(posedge sys_clk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge sys_clk);
      ar = s_axi_arready;
      rv = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(what, dat, d);
    check("rresp", 32'(rsp), 32'(r));
  endtask
  // wait for a {trigd, ready, armed} pattern, bounded
  task automatic waitLights(input logic [2:0] want, input string what);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (lights !== want && n < 600)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(what, 32'(lights), 32'(want));
  endtask
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("acqRun", 32'(acqRun), 32'h0);
    waitLights(3'h0, "reset lights");
    rd(`TAS_CTRL_OFF, 32'h0, okResp, "ctrl");
    rd(`TAS_POSTCNT_OFF, 32'h10, okResp, "post");
    rd(8'h20, 32'h0, errResp, "unmapped");
    wr(`TAS_STAT_OFF, 32'h1, errResp);
    wr(`TAS_PRECNT_OFF, 32'h4, okResp);
    wr(`TAS_POSTCNT_OFF, 32'h8, okResp);
    fp_u.press(2);
    check("forced run", 32'({acqRun, lights}), 32'h0);
    $display("test halt done");
    fp_u.press(4);
    waitLights(3'h1, "arming");
    waitLights(3'h2, "waiting");
    fp_u.press(0);
    waitLights(3'h4, "trig");
    waitLights(3'h1, "rearm");
    fp_u.press(2);
    waitLights(3'h4, "forced");
    $display("test run done");
    wr(`TAS_CTRL_OFF, 32'h4, okResp);
    waitLights(3'h2, "dly ready");
    fp_u.press(0);
    waitLights(3'h6, "main seen");
    repeat (40) @(posedge sys_clk);
    check("early fill", 32'(lights), 32'h6);
    fp_u.press(1);
    waitLights(3'h4, "dly fill");
    fp_u.press(4);
    waitLights(3'h0, "halted");
    $display("test delay done");
    wr(`TAS_CTRL_OFF, 32'h2, okResp);
    fp_u.press(4);
    waitLights(3'h2, "single ready");
    fp_u.press(0);
    waitLights(3'h4, "single trig");
    waitLights(3'h0, "single done");
    repeat (40) @(posedge sys_clk);
    check("single halt", 32'({acqRun, lights}), 32'h0);
    wr(`TAS_CMD_OFF, 32'h8, okResp);
    rd(`TAS_CTRL_OFF, 32'h0, okResp, "single off");
    $display("test single done");
    fp_u.setPeaks(16'h64, 16'hffec);
    rd(`TAS_PEAK_OFF, 32'h0064_ffec, okResp, "peaks");
    wr(`TAS_DLYLVL_OFF, 32'h1234, okResp);
    for (int i = 0; i < 4; i++)
    begin
      wr(`TAS_MAINLVL_OFF, 32'h0, okResp);
      wr(`TAS_CTRL_OFF, 32'(ctrlVal[i]), okResp);
      rd(`TAS_CTRL_OFF, 32'(ctrlVal[i]), okResp, "type");
      fp_u.press(3);
      check("mid level", 32'(mainLevel), 32'(midExp[i]));
      check("source", 32'(trigSource), 32'h3);
      check("dly level", 32'(delayLevel), 32'h1234);
    end
    wr(`TAS_DLYLVL_OFF, 32'h5678, okResp, 4'h1);
    rd(`TAS_DLYLVL_OFF, 32'h1278, okResp, "dly strobe");
    wr(`TAS_CTRL_OFF, 32'h18, okResp);
    rd(`TAS_CTRL_OFF, 32'h0, okResp, "type fold");
    wr(`TAS_CMD_OFF, 32'h2, okResp);
    rd(`TAS_MAINLVL_OFF, 32'h28, okResp, "cmd mid");
    $display("test levels done");
    give_verdict();
  end
endmodule // tas_trigger_sequencer_tb
